// File: hdl/acc_pkg.sv
package acc_pkg;
  // register byte addresses on the avalon word bus
  localparam logic [3:0] ADDR_SHARED   = 4'h0;  // shared_function_control
  localparam logic [3:0] ADDR_CTRL     = 4'h4;  // comparator_control_status
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  // shared_function_control fields
  localparam int SF_MUX_EN_BIT = 3;
  localparam logic [7:0] SF_RESET   = 8'h00;
  localparam logic [7:0] SF_WMASK   = 8'hef;  // bit 4 reads zero
  // comparator_control_status fields
  localparam int CS_PWR_OFF_BIT = 7;
  localparam int CS_BG_BIT      = 6;
  localparam int CS_RESULT_BIT  = 5;
  localparam int CS_FLAG_BIT    = 4;
  localparam int CS_IEN_BIT     = 3;
  localparam int CS_CAPT_BIT    = 2;
  localparam logic [7:0] CS_RESET = 8'h00;
  // interrupt modes
  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL     = 2'h2;
  localparam logic [1:0] MODE_RISE     = 2'h3;
  // wrapper status bits: 0 compare event, 1 result rise, 2 result fall
  localparam int NUM_EVT = 3;
  localparam logic [NUM_EVT-1:0] EVT_RESET = 3'h0;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_ANSWER
  } acc_bus_e;
endpackage

// File: hdl/acc_sync.sv
`timescale 1ns/1ps
module acc_sync
  import acc_pkg::*;
(
  input  wire logic clock,  // system clock
  input  wire logic reset,  // sync reset
  input  wire logic din,    // async level
  output logic      dout    // synchronised level
);
  logic [SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], din};
    end
  end

  assign dout = stage_q[SYNC_STAGES-1];
endmodule

// File: hdl/acc_inmux.sv
`timescale 1ns/1ps
module acc_inmux
  import acc_pkg::*;
(
  input  wire logic       mux_en,       // neg_input_mux_enable
  input  wire logic       conv_en,      // converter_enable
  input  wire logic [2:0] chan_sel,     // channel_select
  input  wire logic       bg_sel,       // bandgap_select
  output logic            pos_use_bg,   // positive input is bandgap
  output logic [7:0]      neg_chan_oh,  // one-hot converter input for negative side
  output logic            neg_use_pin   // negative input is negative_pin
);
  logic use_mux;

  assign use_mux     = mux_en && !conv_en;
  assign neg_use_pin = !use_mux;
  assign pos_use_bg  = bg_sel;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_oh
      assign neg_chan_oh[g] = use_mux && (chan_sel == 3'(g));
    end
  endgenerate
endmodule

// File: hdl/acc_top.sv
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  input  wire logic        clock,             // 10 MHz system clock
  input  wire logic        reset,             // sync, active high
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read strobe
  input  wire logic        avs_write,         // write strobe
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte enables
  output logic [31:0]      avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic        comp_raw,          // analog comparator output, async
  input  wire logic        converter_enable,  // from converter control
  input  wire logic        global_irq_enable, // core global enable
  input  wire logic        vector_ack,        // core entering comparator vector
  output logic             comp_power_down,   // comparator supply off
  output logic             pos_use_bandgap,   // positive input select
  output logic             neg_use_pin,       // negative input is negative_pin
  output logic [7:0]       neg_chan_sel,      // one-hot converter input
  output logic             capture_in,        // to capture timer front end
  output logic             compare_irq,       // comparator interrupt request
  output logic             irq                // wrapper status interrupt
);
  logic [7:0]         sf_q;
  logic [7:0]         cs_q;
  logic               res_q;
  logic               res_sync;
  logic               rise;
  logic               fall;
  logic               match;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] stat_q;
  logic [NUM_EVT-1:0] mask_q;
  logic               pos_bg_c;
  logic               neg_pin_c;
  logic [7:0]         neg_oh_c;
  logic               wr_hit;
  logic               rd_hit;
  logic [31:0]        rd_c;
  acc_bus_e           bus_q;

  // analog comparator itself drives comp_raw high when pos > neg
  acc_sync u_sync (
    .clock (clock),
    .reset (reset),
    .din   (comp_raw),
    .dout  (res_sync)
  );

  acc_inmux u_mux (
    .mux_en      (sf_q[SF_MUX_EN_BIT]),
    .conv_en     (converter_enable),
    .chan_sel    (sf_q[2:0]),
    .bg_sel      (cs_q[CS_BG_BIT]),
    .pos_use_bg  (pos_bg_c),
    .neg_chan_oh (neg_oh_c),
    .neg_use_pin (neg_pin_c)
  );

  // channel_select held in low bits of shared control for this block
  // bus: one wait cycle then answer; keeps readdata registered
  assign wr_hit = avs_write && (bus_q == ACC_IDLE);
  assign rd_hit = avs_read && (bus_q == ACC_IDLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      bus_q <= ACC_IDLE;
    end else begin
      case (bus_q)
        ACC_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= ACC_ANSWER;
          end
        end
        ACC_ANSWER: begin
          bus_q <= ACC_IDLE;
        end
        default: begin
          bus_q <= ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && bus_q == ACC_IDLE);
    end
  end

  always_comb begin
    rd_c = 32'h0;
    case (avs_address)
      ADDR_SHARED:   rd_c = {24'h0, sf_q & SF_WMASK};
      ADDR_CTRL:     rd_c = {24'h0, cs_q[7:6], res_sync, cs_q[4:0]};
      ADDR_IRQ_STAT: rd_c = {29'h0, stat_q};
      ADDR_IRQ_MASK: rd_c = {29'h0, mask_q};
      default:       rd_c = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (rd_hit) begin
      avs_readdata <= rd_c;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sf_q <= SF_RESET;
    end else if (wr_hit && avs_address == ADDR_SHARED && avs_byteenable[0]) begin
      sf_q <= avs_writedata[7:0] & SF_WMASK;
    end
  end

  // result edge detect on synchronised level only
  always_ff @(posedge clock) begin
    if (reset) begin
      res_q <= 1'b0;
    end else begin
      res_q <= res_sync;
    end
  end

  assign rise = res_sync && !res_q;
  assign fall = !res_sync && res_q;

  always_comb begin
    case (cs_q[1:0])
      MODE_TOGGLE:   match = rise || fall;
      MODE_FALL:     match = fall;
      MODE_RISE:     match = rise;
      MODE_RESERVED: match = 1'b0;
      default:       match = 1'b0;
    endcase
  end

  // flag set beats any clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      cs_q <= CS_RESET;
    end else begin
      if (wr_hit && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
        cs_q[7:6] <= avs_writedata[7:6];
        cs_q[3:0] <= avs_writedata[3:0];
        if (avs_writedata[CS_FLAG_BIT]) begin
          cs_q[CS_FLAG_BIT] <= 1'b0;
        end
      end
      if (vector_ack) begin
        cs_q[CS_FLAG_BIT] <= 1'b0;
      end
      if (match && !cs_q[CS_PWR_OFF_BIT]) begin
        cs_q[CS_FLAG_BIT] <= 1'b1;
      end
      cs_q[CS_RESULT_BIT] <= 1'b0;
    end
  end

  assign evt = {fall, rise, match && !cs_q[CS_PWR_OFF_BIT]};

  // read of status clears it; a new event in that cycle survives
  always_ff @(posedge clock) begin
    if (reset) begin
      stat_q <= EVT_RESET;
    end else begin
      stat_q <= ((rd_hit && avs_address == ADDR_IRQ_STAT) ? EVT_RESET : stat_q) | evt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mask_q <= EVT_RESET;
    end else if (wr_hit && avs_address == ADDR_IRQ_MASK && avs_byteenable[0]) begin
      mask_q <= avs_writedata[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq             <= 1'b0;
      compare_irq     <= 1'b0;
      comp_power_down <= 1'b0;
      pos_use_bandgap <= 1'b0;
      neg_use_pin     <= 1'b1;
      neg_chan_sel    <= 8'h00;
      capture_in      <= 1'b0;
    end else begin
      irq             <= |(stat_q & mask_q);
      compare_irq     <= cs_q[CS_FLAG_BIT] && cs_q[CS_IEN_BIT]
                         && global_irq_enable;
      comp_power_down <= cs_q[CS_PWR_OFF_BIT];
      pos_use_bandgap <= pos_bg_c;
      neg_use_pin     <= neg_pin_c;
      neg_chan_sel    <= neg_oh_c;
      capture_in      <= cs_q[CS_CAPT_BIT] && res_sync;
    end
  end

  property p_irq_gate;
    @(posedge clock) disable iff (reset)
    compare_irq |-> $past(cs_q[CS_FLAG_BIT] && cs_q[CS_IEN_BIT] && global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");

  property p_reserved;
    @(posedge clock) disable iff (reset)
    (cs_q[1:0] == MODE_RESERVED && !cs_q[CS_FLAG_BIT] && !vector_ack)
      |=> !cs_q[CS_FLAG_BIT] || $past(cs_q[1:0]) != MODE_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode set flag");

  property p_set;
    @(posedge clock) disable iff (reset)
    (match && !cs_q[CS_PWR_OFF_BIT]) |=> cs_q[CS_FLAG_BIT];
  endproperty
  a_set: assert property (p_set) else $error("event lost");

  property p_rise;
    @(posedge clock) disable iff (reset)
    (cs_q[1:0] == MODE_RISE && fall && !rise) |-> !match;
  endproperty
  a_rise: assert property (p_rise) else $error("rise mode matched fall");

  property p_vec;
    @(posedge clock) disable iff (reset)
    (vector_ack && !match) |=> !cs_q[CS_FLAG_BIT];
  endproperty
  a_vec: assert property (p_vec) else $error("vector did not clear flag");

  sequence s_in_rise;
    $rose(comp_raw);
  endsequence
  property p_sync;
    @(posedge clock) disable iff (reset)
    s_in_rise |-> ##2 res_sync;
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency");

  property p_capt;
    @(posedge clock) disable iff (reset)
    !$past(cs_q[CS_CAPT_BIT]) |-> !capture_in;
  endproperty
  a_capt: assert property (p_capt) else $error("capture route leak");

  property p_neg;
    @(posedge clock) disable iff (reset)
    $past(converter_enable) |-> neg_use_pin && neg_chan_sel == 8'h00;
  endproperty
  a_neg: assert property (p_neg) else $error("mux used with converter on");

  property p_bg;
    @(posedge clock) disable iff (reset)
    pos_use_bandgap == $past(cs_q[CS_BG_BIT]);
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap select wrong");

  property p_pwr;
    @(posedge clock) disable iff (reset)
    comp_power_down == $past(cs_q[CS_PWR_OFF_BIT]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power off not applied");

  property p_w1c;
    @(posedge clock) disable iff (reset)
    (wr_hit && avs_address == ADDR_CTRL && avs_byteenable[0]
      && avs_writedata[CS_FLAG_BIT] && !match) |=> !cs_q[CS_FLAG_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_mode_fall;
    @(posedge clock) disable iff (reset)
    (cs_q[1:0] == MODE_FALL && rise) |-> !match;
  endproperty
  a_mode_fall: assert property (p_mode_fall) else $error("fall mode matched rise");

  property p_result;
    @(posedge clock) disable iff (reset)
    (rd_hit && avs_address == ADDR_CTRL)
      |=> avs_readdata[CS_RESULT_BIT] == $past(res_sync);
  endproperty
  a_result: assert property (p_result) else $error("result bit not synchronised level");

  property p_stat_clr;
    @(posedge clock) disable iff (reset)
    (rd_hit && avs_address == ADDR_IRQ_STAT) |=> stat_q == $past(evt);
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status read did not clear");
endmodule

// File: testbench/acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model #(
  parameter logic [7:0] BG_LVL = 8'h80  // nominal bandgap level
) (
  input  wire logic       clock,       // system clock
  input  wire logic       reset,       // sync reset
  input  wire logic       capture_in,  // routed result at timer front end
  input  wire logic       capt_ien,    // capture_irq_enable in timer mask
  output logic            capt_irq,    // sticky timer capture interrupt
  input  wire logic       power_down,  // comparator supply off
  input  wire logic       use_bg,      // positive side is bandgap
  input  wire logic       use_pin,     // negative side is pin
  input  wire logic [7:0] chan_oh,     // one-hot converter input
  input  wire logic [7:0] pos_lvl,     // positive_pin level
  input  wire logic [7:0] neg_lvl,     // negative_pin level
  input  wire logic [7:0] chan_lvl,    // level on converter inputs
  output logic            raw          // comparator decision
);
  logic [7:0] pos;
  logic [7:0] neg;
  logic       capt_q;

  // timer raises its capture interrupt only with its own mask bit set
  always_ff @(posedge clock) begin
    if (reset) begin
      capt_q   <= 1'b0;
      capt_irq <= 1'b0;
    end else begin
      capt_q   <= capture_in;
      capt_irq <= capt_irq || (capt_ien && capture_in && !capt_q);
    end
  end

  always_comb begin
    pos = use_bg ? BG_LVL : pos_lvl;
    neg = (use_pin || chan_oh == 8'h00) ? neg_lvl : chan_lvl;
    // unpowered core holds low rather than last decision
    raw = !power_down && (pos > neg);
  end
endmodule

// File: testbench/acc_top_test.sv
`timescale 1ns/1ps
module acc_top_test
  import acc_pkg::*;
;
  logic        clock, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        comp_raw, converter_enable, global_irq_enable, vector_ack;
  logic        comp_power_down, pos_use_bandgap, neg_use_pin;
  logic        capture_in, compare_irq, irq;
  logic [7:0]  neg_chan_sel, pos_lvl;
  logic        capt_ien, capt_irq;
  int          fail_count;
  int          checked;
  localparam logic [3:0] EXP_R = 4'b1001;
  localparam logic [3:0] EXP_F = 4'b0101;

  acc_top u_dut (
    .clock             (clock),
    .reset             (reset),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .comp_raw          (comp_raw),
    .converter_enable  (converter_enable),
    .global_irq_enable (global_irq_enable),
    .vector_ack        (vector_ack),
    .comp_power_down   (comp_power_down),
    .pos_use_bandgap   (pos_use_bandgap),
    .neg_use_pin       (neg_use_pin),
    .neg_chan_sel      (neg_chan_sel),
    .capture_in        (capture_in),
    .compare_irq       (compare_irq),
    .irq               (irq)
  );
  acc_analog_model u_model (
    .clock      (clock),
    .reset      (reset),
    .capture_in (capture_in),
    .capt_ien   (capt_ien),
    .capt_irq   (capt_irq),
    .power_down (comp_power_down),
    .use_bg     (pos_use_bandgap),
    .use_pin    (neg_use_pin),
    .chan_oh    (neg_chan_sel),
    .pos_lvl    (pos_lvl),
    .neg_lvl    (8'h40),
    .chan_lvl   (8'h20),
    .raw        (comp_raw)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // holds the request until waitrequest is seen low, then one idle cycle
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk(avs_waitrequest, 0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  // two sync stages, edge detect, then registered outputs: five edges
  task automatic lvl(input logic [7:0] p);
    pos_lvl <= p;
    cyc(5);
  endtask

  initial begin
    #500000;
    fail_count++;
    final_report();
  end

  initial begin
    reset <= 1'b1;
    {avs_read, avs_write, vector_ack, global_irq_enable} <= 4'h0;
    {avs_address, avs_writedata} <= 36'h0;
    avs_byteenable <= 4'h1;
    converter_enable <= 1'b0;
    capt_ien <= 1'b0;
    pos_lvl <= 8'h10;
    cyc(4);
    chk({comp_power_down, pos_use_bandgap, neg_use_pin, neg_chan_sel,
         capture_in, compare_irq, irq}, 32'h0800);
    reset <= 1'b0;
    cyc(1);
    bus(0, ADDR_SHARED, 0);
    chk(rd, {24'h0, SF_RESET});
    bus(0, ADDR_CTRL, 0);
    chk(rd, {24'h0, CS_RESET});
    bus(0, 4'h6, 0);
    chk(rd, 0);
    for (int c = 0; c < 8; c++) begin
      bus(1, ADDR_SHARED, 8'h08 | c[7:0]);
      chk({neg_use_pin, neg_chan_sel}, {1'b0, 8'h01 << c});
    end
    converter_enable <= 1'b1;
    cyc(2);
    chk(neg_use_pin, 1);
    converter_enable <= 1'b0;
    bus(1, ADDR_SHARED, 8'hff);
    bus(0, ADDR_SHARED, 0);
    chk(rd, {24'h0, 8'hff & SF_WMASK});
    bus(1, ADDR_SHARED, 8'h00);
    chk(neg_use_pin, 1);
    bus(1, ADDR_CTRL, 8'hc0);
    chk({comp_power_down, pos_use_bandgap}, 2'b11);
    bus(1, ADDR_CTRL, 8'h04);
    lvl(8'h60);
    chk(capture_in, 1);
    chk(capt_irq, 0);
    bus(0, ADDR_CTRL, 0);
    chk(rd, 32'h34);
    lvl(8'h10);
    capt_ien <= 1'b1;
    lvl(8'h60);
    chk(capt_irq, 1);
    lvl(8'h10);
    bus(1, ADDR_CTRL, 8'h00);
    lvl(8'h60);
    chk(capture_in, 0);
    lvl(8'h10);
    // interrupt enable stays clear across every mode change
    for (int m = 0; m < 4; m++) begin
      bus(1, ADDR_CTRL, {6'h04, m[1:0]});
      lvl(8'h60);
      bus(0, ADDR_CTRL, 0);
      chk(rd[CS_FLAG_BIT], EXP_R[m]);
      bus(1, ADDR_CTRL, {6'h04, m[1:0]});
      lvl(8'h10);
      bus(0, ADDR_CTRL, 0);
      chk(rd[CS_FLAG_BIT], EXP_F[m]);
    end
    // one rise in rise mode leaves the flag pending for the enable tests
    lvl(8'h60);
    lvl(8'h10);
    global_irq_enable <= 1'b1;
    bus(1, ADDR_CTRL, 8'h0b);
    cyc(2);
    chk(compare_irq, 1);
    global_irq_enable <= 1'b0;
    cyc(2);
    chk(compare_irq, 0);
    global_irq_enable <= 1'b1;
    vector_ack <= 1'b1;
    cyc(1);
    vector_ack <= 1'b0;
    cyc(2);
    chk(compare_irq, 0);
    bus(0, ADDR_CTRL, 0);
    chk(rd, 32'h0b);
    lvl(8'h60);
    chk(compare_irq, 1);
    bus(1, ADDR_CTRL, 8'h1b);
    bus(0, ADDR_CTRL, 0);
    chk(rd, 32'h2b);
    bus(1, ADDR_CTRL, 8'h03);
    bus(0, ADDR_IRQ_STAT, 0);
    lvl(8'h10);
    bus(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h04);
    bus(1, ADDR_IRQ_MASK, 8'h02);
    lvl(8'h60);
    chk(irq, 1);
    bus(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h03);
    chk(irq, 0);
    lvl(8'h10);
    chk(irq, 0);
    bus(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'h04);
    final_report();
  end
endmodule
